// [wwd_pkg.sv]
// Shared constants and types of the windowed watchdog.
package wwd_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int unsigned CNT_W = 24;
  localparam int unsigned WARN_W = 10;
  localparam int unsigned ST_W = 4;
  localparam int unsigned PRE_DIV = 4;
  localparam logic [3:0] RST_CYC = 4'h8;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TMO = 8'h04;
  localparam logic [7:0] A_FEED = 8'h08;
  localparam logic [7:0] A_CNT = 8'h0c;
  localparam logic [7:0] A_WARN = 8'h10;
  localparam logic [7:0] A_WIN = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  localparam logic [7:0] A_MASK = 8'h1c;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned C_EN = 0;
  localparam int unsigned C_RST = 1;
  localparam int unsigned C_WIN = 2;
  localparam int unsigned C_CSEL = 3;
  localparam int unsigned S_TMO = 0;
  localparam int unsigned S_WARN = 1;
  localparam int unsigned S_FERR = 2;
  localparam int unsigned S_RFLAG = 3;
  localparam logic [CNT_W-1:0] TMO_RST = 24'hffffff;
  localparam logic [CNT_W-1:0] TMO_MIN = 24'h0000ff;
  localparam logic [CNT_W-1:0] WIN_RST = 24'hffffff;
  localparam logic [WARN_W-1:0] WARN_RST = 10'h000;
  localparam logic [7:0] FEED_KEY1 = 8'haa;
  localparam logic [7:0] FEED_KEY2 = 8'h55;

  typedef enum logic [0:0] {
    FEED_IDLE = 1'b0,
    FEED_ARMED = 1'b1
  } wwd_feed_t;

endpackage

// [wwd_sync.sv]
// Three-stage synchroniser with rising-edge pulse for an oscillator input.
module wwd_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic rise_pulse
);

  logic [2:0] sync_reg;
  logic stable_reg;
  logic agree;

  assign agree = (sync_reg[1] == sync_reg[2]);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], async_in};
  end

  // A level counts only once the last two stages agree, so a metastable
  // settle is never seen as an edge.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stable_reg <= 1'b0;
      rise_pulse <= 1'b0;
    end
    else
    begin
      if (agree)
        stable_reg <= sync_reg[2];
      rise_pulse <= agree && sync_reg[2] && !stable_reg;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_rise_single:
    assert property (rise_pulse |=> !rise_pulse)
    else $error("edge pulse longer than one cycle");

endmodule

// [wwd_prediv.sv]
// Fixed prescaler that passes every DIV-th count tick.
module wwd_prediv #(
  parameter int unsigned DIV = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic in_tick,
  output logic out_tick
);

  localparam int unsigned PW = (DIV < 2) ? 1 : $clog2(DIV);

  if (DIV < 2)
  begin : g_bad_div
    $error("prescaler needs a divisor of at least two");
  end

  logic [PW-1:0] ph_reg;
  logic last;

  assign last = (ph_reg == PW'(DIV - 1));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ph_reg <= '0;
      out_tick <= 1'b0;
    end
    else
    begin
      if (clr)
        ph_reg <= '0;
      else if (in_tick)
        ph_reg <= last ? '0 : ph_reg + 1'b1;
      out_tick <= !clr && in_tick && last;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_div_wrap:
    assert property (out_tick |-> ph_reg == '0)
    else $error("prescaler tick without phase wrap");

endmodule

// [wwd_windowed_watchdog.sv]
// Windowed watchdog: register port, count-down, feed check and responses.
// ****************************************
// Behaviour summary
// ****************************************
// Contract
// - If the counter is not reloaded before it runs out, a chip reset is requested, or only an interrupt when reset response is off.
// - With the window on, a feed counts only once the counter is at or below the window value and before time-out.
// - A warning interrupt can be raised a programmable number of ticks before time-out.
// - Software may set the enable but never clear it; only reset or a watchdog event clears it.
// - A wrong feed sequence requests a chip reset, or only an interrupt when reset response is off.
// - A watchdog reset sets a flag that stays readable after the reset.
// - The 24-bit counter runs on the count clock divided by four, with time-outs of 256 to 2^24 ticks.
// - The count clock is chosen between the internal RC and the low-power oscillator.
// - A watchdog interrupt from time-out, warning or feed error also raises a wake request for the low-power states; the reset flag does not.
module wwd_windowed_watchdog (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic internal_rc_osc,
  input wire logic dedicated_low_power_osc,
  output logic chip_rst_req,
  output logic irq,
  output logic wake_req
);

  // ****************************************
  // Declarations
  // ****************************************
  logic en_reg;
  logic rst_resp_reg;
  logic win_en_reg;
  logic csel_reg;
  logic [wwd_pkg::CNT_W-1:0] tmo_reg;
  logic [wwd_pkg::CNT_W-1:0] win_reg;
  logic [wwd_pkg::WARN_W-1:0] warn_reg;
  logic [wwd_pkg::CNT_W-1:0] cnt_reg;
  logic [wwd_pkg::ST_W-1:0] status_reg;
  logic [wwd_pkg::ST_W-1:0] status_next;
  logic [wwd_pkg::ST_W-1:0] status_set;
  logic [wwd_pkg::ST_W-1:0] mask_reg;
  logic [3:0] rst_cnt_reg;
  wwd_pkg::wwd_feed_t feed_reg;
  wwd_pkg::wwd_feed_t feed_next;
  logic irc_tick;
  logic lp_tick;
  logic watchdog_count_clock_tick;
  logic pre_tick;
  logic wr_feed;
  logic feed_go;
  logic feed_bad;
  logic win_ok;
  logic feed_ok;
  logic ferr;
  logic expire;
  logic warn_hit;
  logic fire;
  logic fire_rst;
  logic load;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = wr_en && (addr == a);
  endfunction

  // ****************************************
  // Count clock source and prescaler
  // ****************************************
  wwd_sync u_irc_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(internal_rc_osc),
    .rise_pulse(irc_tick)
  );

  wwd_sync u_lp_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(dedicated_low_power_osc),
    .rise_pulse(lp_tick)
  );

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      watchdog_count_clock_tick <= 1'b0;
    else
      watchdog_count_clock_tick <= csel_reg ? lp_tick : irc_tick;
  end

  wwd_prediv #(
    .DIV(wwd_pkg::PRE_DIV)
  ) u_prediv (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clr(load),
    .in_tick(watchdog_count_clock_tick),
    .out_tick(pre_tick)
  );

  // ****************************************
  // Feed sequence
  // ****************************************
  assign wr_feed = wr_at(wwd_pkg::A_FEED);

  always_comb
  begin
    feed_next = feed_reg;
    feed_go = 1'b0;
    feed_bad = 1'b0;
    if (!en_reg)
      feed_next = wwd_pkg::FEED_IDLE;
    else if (wr_en)
    begin
      case (feed_reg)
        wwd_pkg::FEED_IDLE:
        begin
          if (wr_feed && wdata[7:0] == wwd_pkg::FEED_KEY1)
            feed_next = wwd_pkg::FEED_ARMED;
          else if (wr_feed)
            feed_bad = 1'b1;
        end
        wwd_pkg::FEED_ARMED:
        begin
          feed_next = wwd_pkg::FEED_IDLE;
          if (wr_feed && wdata[7:0] == wwd_pkg::FEED_KEY2)
            feed_go = 1'b1;
          else
            feed_bad = 1'b1;
        end
        default:
          feed_next = wwd_pkg::FEED_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      feed_reg <= wwd_pkg::FEED_IDLE;
    else
      feed_reg <= feed_next;
  end

  assign win_ok = !win_en_reg || (cnt_reg <= win_reg);
  assign feed_ok = feed_go && win_ok;
  assign ferr = feed_bad || (feed_go && !win_ok);
  assign expire = en_reg && pre_tick && (cnt_reg == '0);
  assign warn_hit = en_reg && pre_tick && (cnt_reg == {14'h0, warn_reg} + 24'h1);
  assign fire = expire || ferr;
  assign fire_rst = fire && rst_resp_reg;
  assign load = !en_reg || feed_ok || fire;

  // ****************************************
  // Control registers
  // ****************************************
  // The enable can only be set by a write; a watchdog event drops it even if
  // a set arrives in the same cycle, so a runaway loop cannot re-arm it.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      en_reg <= 1'b0;
    else if (fire)
      en_reg <= 1'b0;
    else if (wr_at(wwd_pkg::A_CTRL) && wdata[wwd_pkg::C_EN])
      en_reg <= 1'b1;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_resp_reg <= 1'b1;
      win_en_reg <= 1'b0;
      csel_reg <= 1'b0;
    end
    else if (wr_at(wwd_pkg::A_CTRL))
    begin
      rst_resp_reg <= wdata[wwd_pkg::C_RST];
      win_en_reg <= wdata[wwd_pkg::C_WIN];
      if (!en_reg)
        csel_reg <= wdata[wwd_pkg::C_CSEL];
    end
  end

  // Values below the floor are raised to it, so the shortest time-out is 256 ticks.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tmo_reg <= wwd_pkg::TMO_RST;
      win_reg <= wwd_pkg::WIN_RST;
      warn_reg <= wwd_pkg::WARN_RST;
      mask_reg <= '0;
    end
    else
    begin
      if (wr_at(wwd_pkg::A_TMO))
        tmo_reg <= (wdata[23:0] < wwd_pkg::TMO_MIN) ? wwd_pkg::TMO_MIN : wdata[23:0];
      if (wr_at(wwd_pkg::A_WIN))
        win_reg <= wdata[23:0];
      if (wr_at(wwd_pkg::A_WARN))
        warn_reg <= wdata[9:0];
      if (wr_at(wwd_pkg::A_MASK))
        mask_reg <= wdata[wwd_pkg::ST_W-1:0];
    end
  end

  // ****************************************
  // Count-down
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_reg <= wwd_pkg::TMO_RST;
    else if (load)
      cnt_reg <= tmo_reg;
    else if (pre_tick && cnt_reg != '0)
      cnt_reg <= cnt_reg - 24'h1;
  end

  // ****************************************
  // Status, interrupt and reset request
  // ****************************************
  always_comb
  begin
    status_set = '0;
    status_set[wwd_pkg::S_TMO] = expire;
    status_set[wwd_pkg::S_WARN] = warn_hit;
    status_set[wwd_pkg::S_FERR] = ferr;
    status_set[wwd_pkg::S_RFLAG] = fire_rst;
    status_next = status_reg;
    if (wr_at(wwd_pkg::A_STAT))
      status_next = status_reg & ~wdata[wwd_pkg::ST_W-1:0];
    status_next = status_next | status_set;
  end

  // Only the power-on reset or a software write of ones clears the flags; the reset request leaves them
  // standing so software can see why the chip restarted.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      status_reg <= '0;
    else
      status_reg <= status_next;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_cnt_reg <= 4'h0;
      chip_rst_req <= 1'b0;
    end
    else
    begin
      if (fire_rst)
        rst_cnt_reg <= wwd_pkg::RST_CYC;
      else if (rst_cnt_reg != 4'h0)
        rst_cnt_reg <= rst_cnt_reg - 4'h1;
      chip_rst_req <= fire_rst || (rst_cnt_reg > 4'h1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq <= |(status_reg & mask_reg);
      wake_req <= |(status_reg[2:0] & mask_reg[2:0]);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata <= 32'h0;
    else if (!rd_en)
      rdata <= 32'h0;
    else
    begin
      case (addr)
        wwd_pkg::A_CTRL: rdata <= {28'h0, csel_reg, win_en_reg, rst_resp_reg, en_reg};
        wwd_pkg::A_TMO: rdata <= {8'h0, tmo_reg};
        wwd_pkg::A_CNT: rdata <= {8'h0, cnt_reg};
        wwd_pkg::A_WARN: rdata <= {22'h0, warn_reg};
        wwd_pkg::A_WIN: rdata <= {8'h0, win_reg};
        wwd_pkg::A_STAT: rdata <= {28'h0, status_reg};
        wwd_pkg::A_MASK: rdata <= {28'h0, mask_reg};
        default: rdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rst_pulse;
    chip_rst_req [*8] ##1 !chip_rst_req;
  endsequence

  sequence s_bad_second;
    en_reg && feed_reg == wwd_pkg::FEED_ARMED && wr_en && !(wr_feed && wdata[7:0] == wwd_pkg::FEED_KEY2);
  endsequence

  a_expire_reset:
    assert property (expire && rst_resp_reg |=> s_rst_pulse)
    else $error("time-out did not give an eight-cycle reset request");

  a_window_early:
    assert property (feed_go && win_en_reg && cnt_reg > win_reg |=> status_reg[wwd_pkg::S_FERR] && !en_reg)
    else $error("early feed inside closed window was accepted");

  a_warn_flag:
    assert property (warn_hit |=> status_reg[wwd_pkg::S_WARN])
    else $error("warning flag not set");

  a_enable_sticky:
    assert property (en_reg && !fire |=> en_reg)
    else $error("enable dropped without a watchdog event");

  a_enable_drop:
    assert property (fire |=> !en_reg)
    else $error("enable kept after a watchdog event");

  a_feed_error:
    assert property (s_bad_second |=> status_reg[wwd_pkg::S_FERR] && !en_reg)
    else $error("broken feed sequence not flagged");

  a_rflag_kept:
    assert property ($rose(chip_rst_req) |-> status_reg[wwd_pkg::S_RFLAG])
    else $error("reset request without watchdog reset flag");

  a_count_step:
    assert property (en_reg && pre_tick && cnt_reg != '0 && !load |=> cnt_reg == $past(cnt_reg) - 24'h1)
    else $error("counter did not step down by one");

  a_tmo_floor:
    assert property (tmo_reg >= wwd_pkg::TMO_MIN)
    else $error("time-out below 256 ticks");

  a_clk_select:
    assert property (csel_reg && lp_tick |=> watchdog_count_clock_tick)
    else $error("low-power oscillator tick not selected");

  a_wake_req:
    assert property (|(status_reg[2:0] & mask_reg[2:0]) |=> wake_req && irq)
    else $error("interrupt did not raise wake request");

  a_feed_reload:
    assert property (feed_ok |=> cnt_reg == $past(tmo_reg))
    else $error("valid feed did not reload the counter");

endmodule

// [tb_windowed_watchdog_timer.sv]
// Self-checking testbench of the windowed watchdog.
module tb_windowed_watchdog_timer;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Stimulus and design
  // ****************************************
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rc_osc = 1'b0;
  logic lp_osc = 1'b0;
  logic [31:0] rdata;
  logic chip_rst_req;
  logic irq;
  logic wake_req;
  logic [31:0] d;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int rc_cnt = 0;
  int lp_cnt = 0;

  always #2 mclk = ~mclk;

  // The two oscillators run at different rates so a wrong clock select shows in the count.
  always @(posedge mclk)
  begin
    rc_cnt <= (rc_cnt == 3) ? 0 : rc_cnt + 1;
    lp_cnt <= (lp_cnt == 5) ? 0 : lp_cnt + 1;
    if (rc_cnt == 3)
      rc_osc <= ~rc_osc;
    if (lp_cnt == 5)
      lp_osc <= ~lp_osc;
  end

  wwd_windowed_watchdog DUT (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rdata(rdata),
    .internal_rc_osc(rc_osc),
    .dedicated_low_power_osc(lp_osc),
    .chip_rst_req(chip_rst_req),
    .irq(irq),
    .wake_req(wake_req)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A range is needed where the oscillator phase against mclk is free.
  task automatic chkr(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic feed();
    wr(wwd_pkg::A_FEED, {24'h0, wwd_pkg::FEED_KEY1});
    wr(wwd_pkg::A_FEED, {24'h0, wwd_pkg::FEED_KEY2});
  endtask

  task automatic wait_irq(input int lim);
    int i;
    for (i = 0; i < lim && irq !== 1'b1; i++)
      @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_vals();
    rd(wwd_pkg::A_CTRL, d); chk(d, 32'h2);
    rd(wwd_pkg::A_TMO, d); chk(d, 32'hffffff);
    rd(wwd_pkg::A_STAT, d); chk(d, 32'h0);
    rd(8'h20, d); chk(d, 32'h0);
  endtask

  // A broken feed: the first key followed by a write elsewhere.
  task automatic t_feed_err();
    wr(wwd_pkg::A_MASK, 32'h7);
    wr(wwd_pkg::A_CTRL, 32'h1);
    wr(wwd_pkg::A_CTRL, 32'h0);
    rd(wwd_pkg::A_CTRL, d); chk(d, 32'h1);
    wr(wwd_pkg::A_FEED, {24'h0, wwd_pkg::FEED_KEY1});
    wr(wwd_pkg::A_WARN, 32'h0);
    repeat (2) @(posedge mclk);
    chk({29'h0, chip_rst_req, irq, wake_req}, 32'h3);
    rd(wwd_pkg::A_STAT, d); chk(d, 32'h4);
    rd(wwd_pkg::A_CTRL, d); chk(d, 32'h0);
    wr(wwd_pkg::A_STAT, 32'h4);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
  endtask

  // Low-power clock, warning, reload and time-out as interrupt only.
  task automatic t_warn_tmo();
    wr(wwd_pkg::A_TMO, 32'h10); rd(wwd_pkg::A_TMO, d); chk(d, 32'hff);
    wr(wwd_pkg::A_WARN, 32'h80);
    wr(wwd_pkg::A_MASK, 32'h3);
    wr(wwd_pkg::A_CTRL, 32'h9);
    repeat (480) @(posedge mclk);
    rd(wwd_pkg::A_CNT, d); chkr(d, 32'hf3, 32'hf7);
    feed();
    rd(wwd_pkg::A_CNT, d); chkr(d, 32'hfe, 32'hff);
    wait_irq(14000);
    rd(wwd_pkg::A_STAT, d); chk(d, 32'h2);
    rd(wwd_pkg::A_CNT, d); chkr(d, 32'h7f, 32'h81);
    wr(wwd_pkg::A_STAT, 32'h2);
    // The interrupt output lags the clear by one cycle, so let it fall first.
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wait_irq(8000);
    chk({31'h0, chip_rst_req}, 32'h0);
    rd(wwd_pkg::A_STAT, d); chk(d, 32'h1);
    rd(wwd_pkg::A_CTRL, d); chk(d, 32'h8);
    wr(wwd_pkg::A_STAT, 32'h1);
  endtask

  // RC clock, time-out with reset response and the reset flag.
  task automatic t_rst_tmo();
    int i;
    int w;
    w = 0;
    wr(wwd_pkg::A_CTRL, 32'h2);
    wr(wwd_pkg::A_MASK, 32'hf);
    wr(wwd_pkg::A_CTRL, 32'h3);
    repeat (480) @(posedge mclk);
    rd(wwd_pkg::A_CNT, d); chkr(d, 32'hee, 32'hf2);
    for (i = 0; i < 9000 && chip_rst_req !== 1'b1; i++)
      @(posedge mclk);
    for (i = 0; i < 20 && chip_rst_req === 1'b1; i++)
    begin
      w++;
      @(posedge mclk);
    end
    chk(w, 32'h8);
    // The count passes the warning point on its way down, so that flag stands too.
    rd(wwd_pkg::A_STAT, d); chk(d, 32'hb);
    chk({31'h0, irq}, 32'h1);
    wr(wwd_pkg::A_STAT, 32'hf);
  endtask

  // An early feed is refused; a feed inside the window restarts the count.
  task automatic t_window();
    int i;
    wr(wwd_pkg::A_CTRL, 32'h0);
    wr(wwd_pkg::A_WIN, 32'h80);
    wr(wwd_pkg::A_CTRL, 32'h5);
    feed();
    rd(wwd_pkg::A_STAT, d); chk(d, 32'h4);
    wr(wwd_pkg::A_STAT, 32'h4);
    wr(wwd_pkg::A_CTRL, 32'h5);
    d = 32'hff;
    for (i = 0; i < 100 && d > 32'h7e; i++)
    begin
      repeat (60) @(posedge mclk);
      rd(wwd_pkg::A_CNT, d);
    end
    feed();
    // Only the warning, passed while waiting for the window, may stand; no feed error.
    rd(wwd_pkg::A_STAT, d); chk(d, 32'h2);
    rd(wwd_pkg::A_CNT, d); chkr(d, 32'hfe, 32'hff);
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The whole run needs about 25000 cycles; the ceiling leaves room for slow paths.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_feed_err();
    t_warn_tmo();
    t_rst_tmo();
    t_window();
    close_out();
  end
endmodule
